// ===== src/psr_pkg.sv
/*
  Constants, field layout and carrier types for the power supervision
  register block. Assumes a 32-bit APB master and a 200 MHz pclk.
*/
package psr_pkg;

  localparam logic [7:0] OFF_VREG = 8'h00;
  localparam logic [7:0] OFF_OSC = 8'h04;
  localparam logic [7:0] OFF_MON = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // Regulator register fields
  localparam int VR_LOCK = 31;
  localparam int VR_PULLDN = 30;
  localparam int VR_CORE_LVL = 25;
  localparam int VR_IO_LVL = 24;
  localparam int VR_CORE_MASK = 23;
  localparam int VR_CORE_STATE = 22;
  localparam int VR_CORE_EN = 21;
  localparam int VR_IO_MASK = 20;
  localparam int VR_IO_STATE = 19;
  localparam int VR_IO_EN = 18;
  localparam int VR_DEEP_DIS = 17;
  localparam int VR_CAL_DONE = 16;
  localparam int VR_TRIM_LSB = 8;
  localparam int VR_ON = 7;
  localparam int VR_SETTLED = 6;
  localparam int VR_EN = 5;
  localparam int VR_VSEL_LSB = 0;

  // Oscillator register fields
  localparam int OS_CAL_DONE = 16;
  localparam int OS_TRIM_LSB = 0;

  // Supply monitor register fields
  localparam int MN_PERIOD_LSB = 24;
  localparam int MN_ON = 18;
  localparam int MN_LOCK = 17;
  localparam int MN_CAL_DONE = 16;
  localparam int MN_TRIM_LSB = 8;
  localparam int MN_FORCE = 7;
  localparam int MN_MODE_LSB = 0;

  // Interrupt status bits
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_SETTLED = 1;
  localparam int IRQ_SAMPLE = 2;

  // Reset values, plus the sampling period base
  localparam logic [2:0] VSEL_1V8 = 3'h0;
  localparam logic VR_EN_RST = 1'b1;
  localparam logic POR_EN_RST = 1'b1;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] PERIOD_RST = 4'h0;
  localparam logic [4:0] PERIOD_BASE = 5'h05;

  typedef enum logic [1:0] {
    PSR_MON_OFF,
    PSR_MON_RESET_IRQ,
    PSR_MON_IRQ_ONLY
  } psr_mon_mode_t;

  // One calibration load from the flash fuses
  typedef struct packed {
    logic vld;
    logic [9:0] val;
  } psr_cal_t;

  typedef struct packed {
    logic lock;
    logic pulldn;
    logic core_mask;
    logic core_en;
    logic io_mask;
    logic io_en;
    logic deep_dis;
    logic cal_done;
    logic [3:0] trim;
    logic en;
    logic [2:0] vsel;
  } psr_vreg_t;

  typedef struct packed {
    logic [3:0] period;
    logic lock;
    logic cal_done;
    logic [3:0] trim;
    logic force_smp;
    logic [2:0] mode;
  } psr_mon_t;

endpackage : psr_pkg

// ===== src/psr_regs.sv
/*
  Power supervision registers: regulator control, system RC trim and
  3.3V supply monitor, with APB slave, interrupt and sample pacing.
  Assumes presetn is asserted on every reset and por_rst_n only on a
  power-on reset; analog status and the 32kHz tick are synchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module psr_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire psr_pkg::psr_cal_t vreg_cal,
  input wire psr_pkg::psr_cal_t osc_cal,
  input wire psr_pkg::psr_cal_t mon_cal,
  output logic vreg_cal_req,
  output logic osc_cal_req,
  output logic mon_cal_req,
  input wire logic core_por_level,
  input wire logic io_por_level,
  input wire logic core_por_state,
  input wire logic io_por_state,
  input wire logic core_por_trip,
  input wire logic io_por_trip,
  input wire logic regulator_on_state,
  input wire logic regulator_at_level,
  input wire logic monitor_on_state,
  input wire logic monitor_trip,
  input wire logic sleep_low_power,
  input wire logic sleep_deep_static,
  input wire logic rc32k_tick,
  output logic core_por_enable,
  output logic io_por_enable,
  output logic core_por_reset,
  output logic io_por_reset,
  output logic regulator_enable,
  output logic regulator_pulldown_test,
  output logic regulator_deep_mode,
  output logic [2:0] output_voltage_select,
  output logic [3:0] regulator_trim,
  output logic [9:0] osc_trim,
  output logic [3:0] monitor_trim,
  output logic monitor_enable,
  output logic monitor_sampling,
  output logic monitor_sample_req,
  output logic monitor_reset_req,
  output logic irq
);

  function automatic psr_pkg::psr_mon_mode_t mode_dec(input logic [2:0] m);
    psr_pkg::psr_mon_mode_t r;
    r = psr_pkg::PSR_MON_OFF;
    case (m)
      3'h1: r = psr_pkg::PSR_MON_RESET_IRQ;
      3'h2: r = psr_pkg::PSR_MON_IRQ_ONLY;
      default: r = psr_pkg::PSR_MON_OFF;
    endcase
    return r;
  endfunction : mode_dec

  // Last count of a sampling interval, 2^(period+5) ticks
  function automatic logic [20:0] period_last(input logic [3:0] p);
    logic [4:0] sh;
    sh = p + psr_pkg::PERIOD_BASE;
    return 21'(21'h000001 << sh) - 21'h000001;
  endfunction : period_last

  psr_pkg::psr_vreg_t vreg_q;
  psr_pkg::psr_mon_t mon_q;
  logic [9:0] osc_trim_q;
  logic osc_done_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic [20:0] smp_cnt_q;
  logic [3:0] smp_period_q;
  logic smp_active_q;
  logic settled_q;
  logic sample_q;
  logic mon_rst_q;

  logic setup;
  logic wr;
  logic rd;
  logic hit;
  logic settled;
  logic sampling;
  logic mon_on;
  logic trip_ev;
  logic settle_ev;
  logic [2:0] irq_set;
  logic [31:0] vreg_rd;
  logic [31:0] osc_rd;
  logic [31:0] mon_rd;
  psr_pkg::psr_mon_mode_t mode;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign hit = (paddr == psr_pkg::OFF_VREG) | (paddr == psr_pkg::OFF_OSC) |
               (paddr == psr_pkg::OFF_MON) | (paddr == psr_pkg::OFF_IRQ_STAT) |
               (paddr == psr_pkg::OFF_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = rdata_q;

  // Enabled regulator only, and only once the output is up
  assign settled = vreg_q.en & regulator_on_state & regulator_at_level;
  assign mode = mode_dec(mon_q.mode);
  assign mon_on = mode != psr_pkg::PSR_MON_OFF;
  assign sampling = mon_on & (mon_q.force_smp | sleep_deep_static);
  assign trip_ev = mon_on & monitor_trip;
  assign settle_ev = settled & ~settled_q;

  always_comb
  begin
    vreg_rd = 32'h00000000;
    vreg_rd[psr_pkg::VR_LOCK] = vreg_q.lock;
    vreg_rd[psr_pkg::VR_PULLDN] = vreg_q.pulldn;
    vreg_rd[psr_pkg::VR_CORE_LVL] = core_por_level;
    vreg_rd[psr_pkg::VR_IO_LVL] = io_por_level;
    vreg_rd[psr_pkg::VR_CORE_MASK] = vreg_q.core_mask;
    vreg_rd[psr_pkg::VR_CORE_STATE] = core_por_state;
    vreg_rd[psr_pkg::VR_CORE_EN] = vreg_q.core_en;
    vreg_rd[psr_pkg::VR_IO_MASK] = vreg_q.io_mask;
    vreg_rd[psr_pkg::VR_IO_STATE] = io_por_state;
    vreg_rd[psr_pkg::VR_IO_EN] = vreg_q.io_en;
    vreg_rd[psr_pkg::VR_DEEP_DIS] = vreg_q.deep_dis;
    vreg_rd[psr_pkg::VR_CAL_DONE] = vreg_q.cal_done;
    vreg_rd[psr_pkg::VR_TRIM_LSB +: 4] = vreg_q.trim;
    vreg_rd[psr_pkg::VR_ON] = regulator_on_state;
    vreg_rd[psr_pkg::VR_SETTLED] = settled;
    vreg_rd[psr_pkg::VR_EN] = vreg_q.en;
    vreg_rd[psr_pkg::VR_VSEL_LSB +: 3] = vreg_q.vsel;
  end

  always_comb
  begin
    osc_rd = 32'h00000000;
    osc_rd[psr_pkg::OS_CAL_DONE] = osc_done_q;
    osc_rd[psr_pkg::OS_TRIM_LSB +: 10] = osc_trim_q;
  end

  always_comb
  begin
    mon_rd = 32'h00000000;
    mon_rd[psr_pkg::MN_PERIOD_LSB +: 4] = mon_q.period;
    mon_rd[psr_pkg::MN_ON] = monitor_on_state;
    mon_rd[psr_pkg::MN_LOCK] = mon_q.lock;
    mon_rd[psr_pkg::MN_CAL_DONE] = mon_q.cal_done;
    mon_rd[psr_pkg::MN_TRIM_LSB +: 4] = mon_q.trim;
    mon_rd[psr_pkg::MN_FORCE] = mon_q.force_smp;
    mon_rd[psr_pkg::MN_MODE_LSB +: 3] = mon_q.mode;
  end

  // Read data is captured in the setup cycle so it stands in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h00000000;
    else if (setup & ~pwrite)
    begin
      case (paddr)
        psr_pkg::OFF_VREG: rdata_q <= vreg_rd;
        psr_pkg::OFF_OSC: rdata_q <= osc_rd;
        psr_pkg::OFF_MON: rdata_q <= mon_rd;
        psr_pkg::OFF_IRQ_STAT: rdata_q <= {29'h00000000, irq_stat_q};
        psr_pkg::OFF_IRQ_MASK: rdata_q <= {29'h00000000, irq_mask_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Regulator register lives through ordinary resets; only power-on clears it
  always_ff @(posedge pclk or negedge por_rst_n)
  begin
    if (!por_rst_n)
    begin
      vreg_q.lock <= 1'b0;
      vreg_q.pulldn <= 1'b0;
      vreg_q.core_mask <= 1'b0;
      vreg_q.core_en <= psr_pkg::POR_EN_RST;
      vreg_q.io_mask <= 1'b0;
      vreg_q.io_en <= psr_pkg::POR_EN_RST;
      vreg_q.deep_dis <= 1'b0;
      vreg_q.cal_done <= 1'b0;
      vreg_q.trim <= 4'h0;
      vreg_q.en <= psr_pkg::VR_EN_RST;
      vreg_q.vsel <= psr_pkg::VSEL_1V8;
    end
    else
    begin
      if (wr & (paddr == psr_pkg::OFF_VREG) & ~vreg_q.lock)
      begin
        // Level, state, on and settled bits have no storage here
        vreg_q.lock <= pwdata[psr_pkg::VR_LOCK];
        vreg_q.pulldn <= pwdata[psr_pkg::VR_PULLDN];
        vreg_q.core_mask <= pwdata[psr_pkg::VR_CORE_MASK];
        vreg_q.core_en <= pwdata[psr_pkg::VR_CORE_EN];
        vreg_q.io_mask <= pwdata[psr_pkg::VR_IO_MASK];
        vreg_q.io_en <= pwdata[psr_pkg::VR_IO_EN];
        vreg_q.deep_dis <= pwdata[psr_pkg::VR_DEEP_DIS];
        vreg_q.trim <= pwdata[psr_pkg::VR_TRIM_LSB +: 4];
        vreg_q.en <= pwdata[psr_pkg::VR_EN];
        vreg_q.vsel <= pwdata[psr_pkg::VR_VSEL_LSB +: 3];
      end
      // Fuse load wins over a same-cycle software write to the trim
      if (vreg_cal.vld & ~vreg_q.cal_done)
      begin
        vreg_q.trim <= vreg_cal.val[3:0];
        vreg_q.cal_done <= 1'b1;
      end
    end
  end

  // Request a reload after a power-on reset until done; done survives non-POR resets
  assign vreg_cal_req = ~vreg_q.cal_done;

  always_ff @(posedge pclk or negedge por_rst_n)
  begin
    if (!por_rst_n)
    begin
      osc_trim_q <= 10'h000;
      osc_done_q <= 1'b0;
    end
    else
    begin
      if (wr & (paddr == psr_pkg::OFF_OSC))
        osc_trim_q <= pwdata[psr_pkg::OS_TRIM_LSB +: 10];
      if (osc_cal.vld & ~osc_done_q)
      begin
        osc_trim_q <= osc_cal.val;
        osc_done_q <= 1'b1;
      end
    end
  end

  assign osc_cal_req = ~osc_done_q;

  // Monitor register is cleared by any reset, lock included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_q.period <= psr_pkg::PERIOD_RST;
      mon_q.lock <= 1'b0;
      mon_q.cal_done <= 1'b0;
      mon_q.trim <= 4'h0;
      mon_q.force_smp <= 1'b0;
      mon_q.mode <= psr_pkg::MODE_RST;
    end
    else
    begin
      if (wr & (paddr == psr_pkg::OFF_MON) & ~mon_q.lock)
      begin
        mon_q.period <= pwdata[psr_pkg::MN_PERIOD_LSB +: 4];
        mon_q.lock <= pwdata[psr_pkg::MN_LOCK];
        mon_q.trim <= pwdata[psr_pkg::MN_TRIM_LSB +: 4];
        mon_q.force_smp <= pwdata[psr_pkg::MN_FORCE];
        mon_q.mode <= pwdata[psr_pkg::MN_MODE_LSB +: 3];
      end
      if (mon_cal.vld & ~mon_q.cal_done)
      begin
        mon_q.trim <= mon_cal.val[3:0];
        mon_q.cal_done <= 1'b1;
      end
    end
  end

  assign mon_cal_req = ~mon_q.cal_done;

  // Sampling interval counter on slow-clock ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp_cnt_q <= 21'h000000;
      smp_period_q <= psr_pkg::PERIOD_RST;
      smp_active_q <= 1'b0;
      sample_q <= 1'b0;
    end
    else
    begin
      smp_period_q <= mon_q.period;
      smp_active_q <= sampling;
      sample_q <= 1'b0;
      if (~sampling | ~smp_active_q | (smp_period_q != mon_q.period))
        smp_cnt_q <= 21'h000000;
      else if (rc32k_tick)
      begin
        if (smp_cnt_q >= period_last(mon_q.period))
        begin
          smp_cnt_q <= 21'h000000;
          sample_q <= 1'b1;
        end
        else
          smp_cnt_q <= smp_cnt_q + 21'h000001;
      end
    end
  end

  // Reset request held one cycle per trip in the resetting mode only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_rst_q <= 1'b0;
      settled_q <= 1'b0;
    end
    else
    begin
      mon_rst_q <= monitor_trip & (mode == psr_pkg::PSR_MON_RESET_IRQ);
      settled_q <= settled;
    end
  end

  assign irq_set = {sample_q, settle_ev, trip_ev};

  // Read of status clears it; an event in the same cycle is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 3'h0;
    else if (rd & (paddr == psr_pkg::OFF_IRQ_STAT))
      // Clear only what the setup-cycle capture reported; a later set is not lost
      irq_stat_q <= (irq_stat_q & ~rdata_q[2:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= psr_pkg::IRQ_MASK_RST;
    else if (wr & (paddr == psr_pkg::OFF_IRQ_MASK))
      irq_mask_q <= pwdata[2:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  assign core_por_enable = vreg_q.core_en;
  assign io_por_enable = vreg_q.io_en;
  assign core_por_reset = core_por_trip & vreg_q.core_en & ~vreg_q.core_mask;
  assign io_por_reset = io_por_trip & vreg_q.io_en & ~vreg_q.io_mask;
  assign regulator_enable = vreg_q.en;
  assign regulator_pulldown_test = vreg_q.pulldn;
  assign regulator_deep_mode = sleep_low_power & ~vreg_q.deep_dis;
  assign output_voltage_select = vreg_q.vsel;
  assign regulator_trim = vreg_q.trim;
  assign osc_trim = osc_trim_q;
  assign monitor_trim = mon_q.trim;
  assign monitor_enable = mon_on;
  assign monitor_sampling = sampling;
  assign monitor_sample_req = sample_q;
  assign monitor_reset_req = mon_rst_q;

endmodule : psr_regs

`default_nettype wire

// ===== bench/psr_regs_props.sv
/*
  Port-level checker for the power supervision register block.
  Assumes a single pclk domain with presetn as its reset; bound below.
*/
`timescale 1ns/10ps
`default_nettype none

module psr_regs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire psr_pkg::psr_cal_t vreg_cal,
  input wire psr_pkg::psr_cal_t osc_cal,
  input wire logic vreg_cal_req,
  input wire logic osc_cal_req,
  input wire logic core_por_trip,
  input wire logic core_por_enable,
  input wire logic core_por_reset,
  input wire logic sleep_low_power,
  input wire logic regulator_deep_mode,
  input wire logic monitor_enable,
  input wire logic monitor_sampling,
  input wire logic monitor_trip,
  input wire logic monitor_sample_req,
  input wire logic monitor_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  por_out_gate_a: assert property (core_por_reset |-> core_por_trip && core_por_enable)
    else $error("core reset without an enabled trip");
  deep_mode_gate_a: assert property (regulator_deep_mode |-> sleep_low_power)
    else $error("deep mode outside low-power sleep");
  sampling_gate_a: assert property (monitor_sampling |-> monitor_enable)
    else $error("sampling while monitor disabled");
  sample_pulse_a: assert property (monitor_sample_req |=> (!monitor_sample_req) [*8])
    else $error("sample requests too close");
  mon_reset_cause_a: assert property (monitor_reset_req |-> $past(monitor_trip) && $past(monitor_enable))
    else $error("monitor reset without trip");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  vreg_cal_load_a: assert property (vreg_cal.vld && vreg_cal_req |=> !vreg_cal_req)
    else $error("regulator fuse load not taken");
  osc_cal_load_a: assert property (osc_cal.vld && osc_cal_req |=> !osc_cal_req)
    else $error("oscillator fuse load not taken");
endmodule : psr_regs_props

bind psr_regs psr_regs_props psr_regs_props_inst (.pclk, .presetn, .psel, .penable, .pslverr, .vreg_cal,
  .osc_cal, .vreg_cal_req, .osc_cal_req, .core_por_trip, .core_por_enable, .core_por_reset, .sleep_low_power,
  .regulator_deep_mode, .monitor_enable, .monitor_sampling, .monitor_trip, .monitor_sample_req,
  .monitor_reset_req);

`default_nettype wire

// ===== bench/tb.sv
/*
  Self-checking bench for psr_regs: APB master tasks, register table,
  then hand tests for modes, sampling, fuse loads, locks and resets.
  Assumes the checker is bound to the design; 200 MHz pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic pclk, presetn, por_rst_n, psel, penable, pwrite, pready, pslverr, err, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  psr_pkg::psr_cal_t vreg_cal, osc_cal, mon_cal;
  logic vreg_cal_req, osc_cal_req, mon_cal_req, core_por_level, io_por_level, core_por_state;
  logic io_por_state, core_por_trip, io_por_trip, regulator_on_state, regulator_at_level;
  logic monitor_on_state, monitor_trip, sleep_low_power, sleep_deep_static, rc32k_tick, tick_on;
  logic core_por_enable, io_por_enable, core_por_reset, io_por_reset, regulator_enable;
  logic regulator_pulldown_test, regulator_deep_mode, monitor_enable, monitor_sampling;
  logic monitor_sample_req, monitor_reset_req, irq;
  logic [2:0] output_voltage_select;
  logic [3:0] regulator_trim, monitor_trim;
  logic [9:0] osc_trim;
  int fails, total_checks;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} psr_row_t;
  psr_row_t rows [7] = '{'{8'h00, 32'h7FFF_FFFF, 32'h40B6_0F27}, '{8'h00, 32'h0, 32'h0},
    '{8'h04, 32'hFFFF_FFFF, 32'h0000_03FF}, '{8'h08, 32'hFFFD_FFFF, 32'h0F00_0F87},
    '{8'h10, 32'hFFFF_FFFF, 32'h7}, '{8'h10, 32'h0, 32'h0}, '{8'h08, 32'h0, 32'h0}};
  wire [31:0] outs = {16'h0, irq, monitor_reset_req, monitor_sample_req, monitor_sampling, monitor_enable,
    regulator_deep_mode, regulator_pulldown_test, regulator_enable, io_por_reset, core_por_reset,
    io_por_enable, core_por_enable, vreg_cal_req, osc_cal_req, mon_cal_req, err};

  psr_regs psr_regs_inst (.pclk, .presetn, .por_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .vreg_cal, .osc_cal, .mon_cal, .vreg_cal_req, .osc_cal_req, .mon_cal_req,
    .core_por_level, .io_por_level, .core_por_state, .io_por_state, .core_por_trip, .io_por_trip,
    .regulator_on_state, .regulator_at_level, .monitor_on_state, .monitor_trip, .sleep_low_power,
    .sleep_deep_static, .rc32k_tick, .core_por_enable, .io_por_enable, .core_por_reset, .io_por_reset,
    .regulator_enable, .regulator_pulldown_test, .regulator_deep_mode, .output_voltage_select,
    .regulator_trim, .osc_trim, .monitor_trim, .monitor_enable, .monitor_sampling, .monitor_sample_req,
    .monitor_reset_req, .irq);

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Slow clock tick every other pclk cycle, far faster than real but same counting
  always @(posedge pclk) rc32k_tick <= tick_on & ~rc32k_tick;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      wrap_up;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic rst(input logic por);
    presetn <= 1'b0;
    por_rst_n <= ~por;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_rst_n <= 1'b1;
    @(posedge pclk);
  endtask : rst

  task automatic fuse(input logic [9:0] v);
    vreg_cal <= '{vld: 1'b1, val: v};
    osc_cal <= '{vld: 1'b1, val: v};
    mon_cal <= '{vld: 1'b1, val: v};
    @(posedge pclk);
    vreg_cal.vld <= 1'b0;
    osc_cal.vld <= 1'b0;
    mon_cal.vld <= 1'b0;
    @(posedge pclk);
  endtask : fuse

  // Counts slow ticks until the next sample request; a missing pulse ends the run
  task automatic wait_req(output int c);
    c = 0;
    for (int k = 0; k < 400; k++)
    begin
      @(posedge pclk);
      if (monitor_sample_req === 1'b1)
        return;
      c += int'(rc32k_tick);
    end
    fails++;
    wrap_up;
  endtask : wait_req

  initial
  begin
    int c;
    {psel, penable, pwrite, core_por_level, io_por_level, core_por_state, io_por_state, core_por_trip,
      io_por_trip, regulator_on_state, regulator_at_level, monitor_on_state, monitor_trip, sleep_low_power,
      sleep_deep_static, tick_on, err} = '0;
    {paddr, pwdata, vreg_cal, osc_cal, mon_cal, fails, total_checks} = '0;
    rst(1'b1);
    rchk(psr_pkg::OFF_VREG, 32'h0024_0020);
    rchk(psr_pkg::OFF_OSC, 32'h0);
    rchk(psr_pkg::OFF_MON, 32'h0);
    rchk(8'h14, 32'h0);
    chk(outs, 32'h0000_013F);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    {core_por_trip, io_por_trip, sleep_low_power} <= 3'h7;
    apb(1'b1, psr_pkg::OFF_VREG, 32'h40A4_0020);
    chk(outs & 32'h7FF, 32'h7BE);
    apb(1'b1, psr_pkg::OFF_VREG, 32'h0032_0000);
    chk(outs & 32'h7FF, 32'h5E);
    {core_por_trip, io_por_trip, sleep_low_power} <= 3'h0;
    {core_por_level, io_por_level, core_por_state, io_por_state, regulator_on_state, regulator_at_level} <= '1;
    apb(1'b1, psr_pkg::OFF_VREG, 32'h0000_0020);
    rchk(psr_pkg::OFF_VREG, 32'h0348_00E0);
    apb(1'b1, psr_pkg::OFF_VREG, 32'h0);
    rchk(psr_pkg::OFF_VREG, 32'h0348_0080);
    {core_por_level, io_por_level, core_por_state, io_por_state, regulator_on_state, regulator_at_level} <= '0;
    apb(1'b1, psr_pkg::OFF_IRQ_MASK, 32'h1);
    rchk(psr_pkg::OFF_IRQ_STAT, 32'h2);
    for (int m = 0; m < 8; m++)
    begin
      e = (m == 1 || m == 2);
      apb(1'b1, psr_pkg::OFF_MON, {29'h0, 3'(m)});
      monitor_trip <= 1'b1;
      @(posedge pclk);
      monitor_trip <= 1'b0;
      #1;
      chk(outs & 32'hC800, {16'h0, e, m == 1, 2'b0, e, 11'h0});
      @(posedge pclk);
      rchk(psr_pkg::OFF_IRQ_STAT, {31'h0, e});
      chk(outs & 32'h8000, 32'h0);
    end
    apb(1'b1, psr_pkg::OFF_MON, 32'h2);
    chk(outs & 32'h1000, 32'h0);
    sleep_deep_static <= 1'b1;
    @(posedge pclk);
    chk(outs & 32'h1000, 32'h1000);
    sleep_deep_static <= 1'b0;
    tick_on <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, psr_pkg::OFF_MON, {4'h0, 4'(p), 16'h0, 8'h82});
      wait_req(c);
      wait_req(c);
      chk(c, 32 << p);
    end
    tick_on <= 1'b0;
    // Monitor off before its trim is reloaded, so no false trip
    apb(1'b1, psr_pkg::OFF_MON, 32'h0);
    rchk(psr_pkg::OFF_IRQ_STAT, 32'h4);
    for (int j = 0; j < 2; j++)
    begin
      fuse(j ? 10'h15A : 10'h2A5);
      rchk(psr_pkg::OFF_VREG, 32'h0001_0500);
      rchk(psr_pkg::OFF_OSC, 32'h0001_02A5);
      rchk(psr_pkg::OFF_MON, 32'h0001_0500);
    end
    chk(outs & 32'hE, 32'h0);
    chk({11'h000, output_voltage_select, regulator_trim, osc_trim, monitor_trim},
      {11'h000, 3'h0, 4'h5, 10'h2A5, 4'h5});
    rst(1'b0);
    chk(outs & 32'hE, 32'h2);
    rchk(psr_pkg::OFF_VREG, 32'h0001_0500);
    rchk(psr_pkg::OFF_MON, 32'h0);
    apb(1'b1, psr_pkg::OFF_VREG, 32'h8000_0523);
    apb(1'b1, psr_pkg::OFF_VREG, 32'h0);
    rchk(psr_pkg::OFF_VREG, 32'h8001_0523);
    apb(1'b1, psr_pkg::OFF_MON, 32'h0002_0001);
    apb(1'b1, psr_pkg::OFF_MON, 32'h0);
    rchk(psr_pkg::OFF_MON, 32'h0002_0001);
    rst(1'b0);
    rchk(psr_pkg::OFF_VREG, 32'h8001_0523);
    apb(1'b1, psr_pkg::OFF_MON, 32'h2);
    rchk(psr_pkg::OFF_MON, 32'h2);
    rst(1'b1);
    rchk(psr_pkg::OFF_VREG, 32'h0024_0020);
    wrap_up;
  end
endmodule : tb

`default_nettype wire
